// ### shared/aise_params.svh
`ifndef AISE_PARAMS_SVH
`define AISE_PARAMS_SVH

// Register byte offsets on the controller register port.
`define AISE_OFF_PRI_STATUS 8'h28
`define AISE_OFF_PRI_ENABLE 8'h38
`define AISE_OFF_AUX_STATUS 8'h80
`define AISE_OFF_AUX_ENABLE 8'h84

// Field positions inside the auxiliary registers.
`define AISE_BIT_TX_EARLY    31
`define AISE_BIT_RX_EARLY    30
`define AISE_BIT_TRANSCEIVER        29
`define AISE_BIT_TX_DEFER    28
`define AISE_BIT_PAUSE_RX    26
`define AISE_BIT_NORMAL_SUM  16
`define AISE_BIT_ABNORM_SUM  15
`define AISE_TS_MSB          22
`define AISE_TS_LSB          20
`define AISE_RS_MSB          19
`define AISE_RS_LSB          17

// Implemented bit masks; every other bit reads as zero, save the live sequencer states at aux status bits 22:17.
`define AISE_STICKY_MASK     32'hf401ffff
`define AISE_ENABLE_MASK     32'hf401ffff
`define AISE_PRI_MASK        32'h00007fff

// Reset values.
`define AISE_STATUS_RESET    32'h00000000
`define AISE_ENABLE_RESET    32'h00000000

`endif

// ### shared/aise_pkg.sv
`default_nettype none

package aise_pkg;

   // Transmit sequencer state as reported in the auxiliary status word.
   typedef enum logic [2:0] {
      AISE_TX_STOP      = 3'b000,
      AISE_TX_FETCH     = 3'b001,
      AISE_TX_SEND      = 3'b010,
      AISE_TX_FILL      = 3'b011,
      AISE_TX_RSVD4     = 3'b100,
      AISE_TX_RSVD5     = 3'b101,
      AISE_TX_SUSPEND   = 3'b110,
      AISE_TX_WRITEBACK = 3'b111
   } aise_tx_state_e;

   // Receive sequencer state as reported in the auxiliary status word.
   typedef enum logic [2:0] {
      AISE_RX_STOP      = 3'b000,
      AISE_RX_FETCH     = 3'b001,
      AISE_RX_CHECK     = 3'b010,
      AISE_RX_WAIT      = 3'b011,
      AISE_RX_SUSPEND   = 3'b100,
      AISE_RX_WRITEBACK = 3'b101,
      AISE_RX_FLUSH     = 3'b110,
      AISE_RX_DRAIN     = 3'b111
   } aise_rx_state_e;

   // One register port access, valid for a single cycle.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } aise_csr_req_s;

   // Event pulses from the controller, one cycle each.
   typedef struct packed {
      logic        tx_early;
      logic        rx_early;
      logic [6:0]  transceiver_flags;
      logic        tx_deferred;
      logic        pause_rx;
      logic [14:0] primary;
   } aise_events_s;

endpackage

`default_nettype wire

// ### rtl/aise_sticky_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "aise_params.svh"

module aise_sticky_bank (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Set and write-one-clear vectors.
   input  wire logic [31:0] set_i,
   input  wire logic [31:0] clr_i,
   // Stored status bits.
   output logic      [31:0] bits_o
);

   // A set in the same cycle as its clear wins, so no event is lost.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bits_o <= `AISE_STATUS_RESET;
      end else begin
         bits_o <= ((bits_o & ~clr_i) | set_i) & `AISE_STICKY_MASK;
      end
   end

endmodule
`default_nettype wire

// ### rtl/aise_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "aise_params.svh"

module aise_core (
   // Clock and reset.
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   // Register port.
   input  wire aise_pkg::aise_csr_req_s csr_i,
   output logic                  [31:0] csr_rdata_o,
   output logic                         csr_rvalid_o,
   // Sequencer states and events.
   input  wire aise_pkg::aise_tx_state_e tx_state_i,
   input  wire aise_pkg::aise_rx_state_e rx_state_i,
   input  wire aise_pkg::aise_events_s  events_i,
   // Shared primary status and enable bits.
   output logic                  [14:0] primary_status_o,
   output logic                  [14:0] primary_enable_o,
   // Added interrupt contributions to the primary summaries.
   output logic                         add_normal_irq_o,
   output logic                         add_abnormal_irq_o
);

   // Address compare used for every register decode.
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   logic [31:0] status;
   logic [31:0] enable;
   logic [31:0] next_enable;
   logic [31:0] next_rdata;
   logic        next_normal;
   logic        next_abnormal;

   // Register decode.
   wire hit_pri_st = addr_hit(csr_i.addr, `AISE_OFF_PRI_STATUS);
   wire hit_pri_en = addr_hit(csr_i.addr, `AISE_OFF_PRI_ENABLE);
   wire hit_aux_st = addr_hit(csr_i.addr, `AISE_OFF_AUX_STATUS);
   wire hit_aux_en = addr_hit(csr_i.addr, `AISE_OFF_AUX_ENABLE);
   wire wr_pri_st  = csr_i.wr && hit_pri_st;
   wire wr_pri_en  = csr_i.wr && hit_pri_en;
   wire wr_aux_st  = csr_i.wr && hit_aux_st;
   wire wr_aux_en  = csr_i.wr && hit_aux_en;

   // Set conditions of the added sources.
   wire set_tx_early = events_i.tx_early && enable[`AISE_BIT_TX_EARLY];
   wire set_rx_early = events_i.rx_early && enable[`AISE_BIT_RX_EARLY];
   wire set_transceiver     = |events_i.transceiver_flags;
   wire set_normal   = set_tx_early || set_rx_early;
   wire set_abnormal = set_transceiver || events_i.tx_deferred || events_i.pause_rx;

   // Set vector: primary events land in the same low bits both views share.
   wire [31:0] set_vec = {set_tx_early, set_rx_early, set_transceiver, events_i.tx_deferred,
                          1'b0, events_i.pause_rx, 9'h000, set_normal, set_abnormal,
                          events_i.primary};

   // Either status address clears the shared low bits; only the aux one reaches the rest.
   wire [31:0] clr_aux = wr_aux_st ? csr_i.wdata : 32'h00000000;
   wire [31:0] clr_pri = wr_pri_st ? (csr_i.wdata & `AISE_PRI_MASK) : 32'h00000000;
   wire [31:0] clr_vec = clr_aux | clr_pri;

   aise_sticky_bank u_status (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .set_i   (set_vec),
      .clr_i   (clr_vec),
      .bits_o  (status)
   );

   // Enable writes: low bits shared with the primary enable register.
   assign next_enable = wr_aux_en ? (csr_i.wdata & `AISE_ENABLE_MASK) :
                        wr_pri_en ? {enable[31:15], csr_i.wdata[14:0]} :
                        enable;

   // Auxiliary status view with live sequencer states, reserved bits zero.
   wire [31:0] aux_status_view = {status[31:23], tx_state_i, rx_state_i,
                                  status[16:0]};

   // Read data selection; unmapped addresses read zero.
   assign next_rdata = hit_aux_st ? aux_status_view :
                       hit_aux_en ? enable :
                       hit_pri_st ? {17'h00000, status[14:0]} :
                       hit_pri_en ? {17'h00000, enable[14:0]} :
                       32'h00000000;

   // Folding of enabled added sources into the primary summaries.
   assign next_normal = enable[`AISE_BIT_NORMAL_SUM] &&
                        (|(status[31:30] & enable[31:30]));
   assign next_abnormal = enable[`AISE_BIT_ABNORM_SUM] &&
                          (|(status[29:26] & enable[29:26]));

   // Enable register.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         enable <= `AISE_ENABLE_RESET;
      end else begin
         enable <= next_enable;
      end
   end

   // Registered read port and summary outputs.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         csr_rdata_o        <= 32'h00000000;
         csr_rvalid_o       <= 1'b0;
         add_normal_irq_o   <= 1'b0;
         add_abnormal_irq_o <= 1'b0;
      end else begin
         csr_rdata_o        <= csr_i.rd ? next_rdata : 32'h00000000;
         csr_rvalid_o       <= csr_i.rd;
         add_normal_irq_o   <= next_normal;
         add_abnormal_irq_o <= next_abnormal;
      end
   end

   // Shared low bits go straight out from their flip-flops.
   assign primary_status_o = status[14:0];
   assign primary_enable_o = enable[14:0];

   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_aux_status_read;
      csr_i.rd && hit_aux_st;
   endsequence

   sequence s_normal_cause;
      enable[`AISE_BIT_NORMAL_SUM] && status[31] && enable[31] && !wr_aux_st && !wr_pri_en;
   endsequence

   sequence s_abnormal_cause;
      enable[`AISE_BIT_ABNORM_SUM] && status[28] && enable[28] && !wr_aux_st && !wr_aux_en;
   endsequence

   tx_state_view_a: assert property (s_aux_status_read |=>
      csr_rvalid_o && csr_rdata_o[22:20] == $past(tx_state_i))
      else $error("transmit state misreported");

   rx_state_view_a: assert property (s_aux_status_read |=>
      csr_rdata_o[19:17] == $past(rx_state_i))
      else $error("receive state misreported");

   normal_summary_set_a: assert property ((events_i.rx_early && enable[30]) |=>
      status[`AISE_BIT_NORMAL_SUM] && status[30])
      else $error("normal summary not set");

   abnormal_summary_set_a: assert property (events_i.tx_deferred |=>
      status[`AISE_BIT_ABNORM_SUM] && status[28])
      else $error("abnormal summary not set");

   shared_clear_a: assert property ((wr_pri_st && csr_i.wdata[0] && !events_i.primary[0]) |=>
      !status[0] && !primary_status_o[0])
      else $error("primary clear missed shared bit");

   sticky_hold_a: assert property ((status[31] && !(wr_aux_st && csr_i.wdata[31])) |=>
      status[31])
      else $error("sticky bit dropped without clear");

   set_wins_a: assert property ((events_i.tx_deferred && wr_aux_st && csr_i.wdata[28]) |=>
      status[28])
      else $error("clear beat a same-cycle set");

   enable_write_a: assert property (wr_aux_en |=>
      enable[31:26] == ($past(csr_i.wdata[31:26]) & 6'h3d))
      else $error("enable bits not written");

   normal_fold_a: assert property (s_normal_cause |=> add_normal_irq_o)
      else $error("normal fold missing");

   abnormal_fold_a: assert property (s_abnormal_cause |=> add_abnormal_irq_o)
      else $error("abnormal fold missing");

   no_fold_a: assert property (!enable[`AISE_BIT_ABNORM_SUM] |=> !add_abnormal_irq_o)
      else $error("abnormal fold without enable");

   transceiver_or_a: assert property ((|events_i.transceiver_flags) |=> status[29])
      else $error("transceiver status not set");

   reserved_zero_a: assert property ((csr_i.rd && hit_aux_en) |=>
      csr_rdata_o[27] == 1'b0 && csr_rdata_o[25:17] == 9'h000)
      else $error("reserved enable bits not zero");

   pri_enable_write_a: assert property (wr_pri_en |=>
      enable[14:0] == $past(csr_i.wdata[14:0]) && enable[31:15] == $past(enable[31:15]))
      else $error("primary enable write misplaced");

   pri_clear_keep_a: assert property ((wr_pri_st && status[28]) |=>
      status[28])
      else $error("primary clear reached an added bit");

   reserved_status_a: assert property (
      status[27] == 1'b0 && status[25:17] == 9'h000)
      else $error("reserved status bits not zero");

   tx_early_gate_a: assert property ((!enable[`AISE_BIT_TX_EARLY] && !status[31]) |=>
      !status[31])
      else $error("transmit early set while disabled");

   rx_early_gate_a: assert property ((!enable[`AISE_BIT_RX_EARLY] && !status[30]) |=>
      !status[30])
      else $error("receive early set while disabled");

   normal_no_fold_a: assert property (!enable[`AISE_BIT_NORMAL_SUM] |=>
      !add_normal_irq_o)
      else $error("normal fold without enable");

endmodule
`default_nettype wire

// ### test/aux_interrupt_status_enable_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "aise_params.svh"

module aux_interrupt_status_enable_bench;

   // Design stimulus and observation.
   logic                     clk_i;
   logic                     reset_i;
   aise_pkg::aise_csr_req_s  csr_i;
   logic              [31:0] csr_rdata_o;
   logic                     csr_rvalid_o;
   aise_pkg::aise_tx_state_e tx_state_i;
   aise_pkg::aise_rx_state_e rx_state_i;
   aise_pkg::aise_events_s   events_i;
   logic              [14:0] primary_status_o;
   logic              [14:0] primary_enable_o;
   logic                     add_normal_irq_o;
   logic                     add_abnormal_irq_o;
   aise_pkg::aise_events_s   ev;
   int                       fail_count = 0;
   int                       tests_run = 0;

   aise_core dut (
      .clk_i              (clk_i),
      .reset_i            (reset_i),
      .csr_i              (csr_i),
      .csr_rdata_o        (csr_rdata_o),
      .csr_rvalid_o       (csr_rvalid_o),
      .tx_state_i         (tx_state_i),
      .rx_state_i         (rx_state_i),
      .events_i           (events_i),
      .primary_status_o   (primary_status_o),
      .primary_enable_o   (primary_enable_o),
      .add_normal_irq_o   (add_normal_irq_o),
      .add_abnormal_irq_o (add_abnormal_irq_o)
   );

   // The clock toggles every half period of 20 ns.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Single-cycle write strobe; every task starts and ends 1 ns after an edge.
   // An idle cycle follows, so the next call never drives the port in the release step.
   task automatic csr_write(input logic [7:0] addr, input logic [31:0] data);
      csr_i = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clk_i);
      #1;
      csr_i = '0;
      @(posedge clk_i);
      #1;
   endtask

   // Read strobe; the answer must stand in the cycle after the taking edge.
   task automatic csr_read(input logic [7:0] addr, input logic [31:0] exp);
      csr_i = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
      @(posedge clk_i);
      #1;
      check({31'h0, csr_rvalid_o}, 32'h1);
      check(csr_rdata_o, exp);
      csr_i = '0;
      @(posedge clk_i);
      #1;
   endtask

   // Pulses one event, checks irq outputs, latching, clear by one and the cleared state.
   task automatic ev_case(input aise_pkg::aise_events_s e, input logic [31:0] en,
                          input logic [31:0] stat, input logic nirq, input logic airq);
      csr_write(`AISE_OFF_AUX_ENABLE, en);
      events_i = e;
      @(posedge clk_i);
      #1;
      events_i = '0;
      @(posedge clk_i);
      #1;
      check({30'h0, add_normal_irq_o, add_abnormal_irq_o}, {30'h0, nirq, airq});
      csr_write(`AISE_OFF_AUX_STATUS, 32'h0);
      csr_read(`AISE_OFF_AUX_STATUS, stat);
      csr_write(`AISE_OFF_AUX_STATUS, stat);
      csr_read(`AISE_OFF_AUX_STATUS, 32'h0);
      csr_write(`AISE_OFF_AUX_ENABLE, 32'h0);
   endtask

   // Prints the verdict and ends the run.
   task automatic test_done();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #200000;
      fail_count++;
      test_done();
   end

   // Main sequence of register accesses and event pulses.
   initial begin
      reset_i = 1'b1;
      csr_i = '0;
      tx_state_i = aise_pkg::AISE_TX_STOP;
      rx_state_i = aise_pkg::AISE_RX_STOP;
      events_i = '0;
      repeat (12) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      csr_read(`AISE_OFF_AUX_STATUS, `AISE_STATUS_RESET);
      csr_read(`AISE_OFF_AUX_ENABLE, `AISE_ENABLE_RESET);
      csr_read(8'h90, 32'h0);
      csr_write(`AISE_OFF_AUX_ENABLE, 32'hffffffff);
      csr_read(`AISE_OFF_AUX_ENABLE, 32'hf401ffff);
      csr_read(`AISE_OFF_PRI_ENABLE, 32'h00007fff);
      check({17'h0, primary_enable_o}, 32'h00007fff);
      csr_write(`AISE_OFF_PRI_ENABLE, 32'h00005a5a);
      csr_read(`AISE_OFF_AUX_ENABLE, 32'hf401da5a);
      check({17'h0, primary_enable_o}, 32'h00005a5a);
      csr_write(`AISE_OFF_AUX_ENABLE, 32'h0);
      for (int i = 0; i < 8; i++) begin
         tx_state_i = aise_pkg::aise_tx_state_e'(i[2:0]);
         rx_state_i = aise_pkg::aise_rx_state_e'(3'(7 - i));
         csr_read(`AISE_OFF_AUX_STATUS, {9'h0, i[2:0], 3'(7 - i), 17'h0});
         check({30'h0, add_normal_irq_o, add_abnormal_irq_o}, 32'h0);
      end
      tx_state_i = aise_pkg::AISE_TX_STOP;
      rx_state_i = aise_pkg::AISE_RX_STOP;
      ev = '0;
      ev.tx_early = 1'b1;
      ev_case(ev, 32'h80010000, 32'h80010000, 1'b1, 1'b0);
      ev_case(ev, 32'h80000000, 32'h80010000, 1'b0, 1'b0);
      ev_case(ev, 32'h00010000, 32'h00000000, 1'b0, 1'b0);
      ev = '0;
      ev.rx_early = 1'b1;
      ev_case(ev, 32'h40010000, 32'h40010000, 1'b1, 1'b0);
      ev = '0;
      ev.tx_deferred = 1'b1;
      ev_case(ev, 32'h10008000, 32'h10008000, 1'b0, 1'b1);
      ev_case(ev, 32'h10000000, 32'h10008000, 1'b0, 1'b0);
      ev = '0;
      ev.pause_rx = 1'b1;
      ev_case(ev, 32'h04008000, 32'h04008000, 1'b0, 1'b1);
      for (int k = 0; k < 7; k++) begin
         ev = '0;
         ev.transceiver_flags = 7'(1 << k);
         ev_case(ev, 32'h20008000, 32'h20008000, 1'b0, 1'b1);
      end
      ev = '0;
      ev.primary = 15'h4001;
      ev_case(ev, 32'h0, 32'h00004001, 1'b0, 1'b0);
      ev.tx_deferred = 1'b1;
      events_i = ev;
      @(posedge clk_i);
      #1;
      events_i = '0;
      check({17'h0, primary_status_o}, 32'h00004001);
      csr_read(`AISE_OFF_PRI_STATUS, 32'h00004001);
      csr_write(`AISE_OFF_PRI_STATUS, 32'hffffffff);
      csr_read(`AISE_OFF_AUX_STATUS, 32'h10008000);
      test_done();
   end

endmodule

`default_nettype wire
